// [inc/dac_cmd_defines.vh]
// Purpose: constants for the quad dac serial command decoder
// Assumes: 24-bit frames shifted msb first
// Notes: field positions, select codes, function codes, reset values
`ifndef DAC_CMD_DEFINES_VH
`define DAC_CMD_DEFINES_VH
`define FRAME_BITS        24
`define FRAME_CNT_W       5
`define BIT_DIR           23
`define BIT_ZERO          22
`define SEL_HI            21
`define SEL_LO            19
`define ADR_HI            18
`define ADR_LO            16
`define SEL_FUNCTION      3'h0
`define SEL_DATA          3'h2
`define SEL_COARSE        3'h3
`define SEL_FINE          3'h4
`define SEL_OFFSET        3'h5
`define ADR_ALL           3'h4
`define FN_NOP            3'h0
`define FN_CONTROL        3'h1
`define FN_CLEAR          3'h4
`define FN_LOAD           3'h5
`define CW_GND_ADJ        5
`define CW_P1_DIR         4
`define CW_P1_VAL         3
`define CW_P0_DIR         2
`define CW_P0_VAL         1
`define CW_SDO_DIS        0
`define CW_RESET          6'h00
`define RANGE_W           2
`define FINE_W            6
`define OFFSET_W          8
`define CODE_MID          16'h0000
`define CODE_NEG_FULL     16'h0000
`endif

// [src/pin_sync.v]
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  always @(posedge clk) begin
    if (srst) begin
      // reset to the idle level so no false edge follows reset
      stage1   <= INIT;
      sync_out <= INIT;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pin_sync
`default_nettype wire

// [src/quad_dac_serial_command_decode.v]
// Purpose: serial command decoder of a quad 16-bit dac
// Assumes: host drives sclk, frame_sync_n, sdin; sclk sampled by clk
// Notes: data taken on falling sclk, sdo changes on rising sclk
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmd_defines.vh"
module quad_dac_serial_command_decode (
  input  wire        clk,
  input  wire        srst,
  input  wire        sclk,
  input  wire        frame_sync_n,
  input  wire        sdin,
  input  wire        twos_complement,
  input  wire        general_pin_zero_in,
  input  wire        general_pin_one_in,
  output reg         general_pin_zero_out,
  output reg         general_pin_zero_oe,
  output reg         general_pin_one_out,
  output reg         general_pin_one_oe,
  output reg         serial_out_pin,
  output reg         serial_out_pin_oe,
  output reg         ground_adjust_en,
  output reg  [63:0] dac_output_code,
  output reg  [7:0]  range_codes,
  output reg  [23:0] fine_gains,
  output reg  [31:0] offsets,
  output reg         frame_done
);
  wire [4:0] pins_s;
  wire       sclk_s;
  wire       fs_n_s;
  wire       sdin_s;
  wire       gp0_s;
  wire       gp1_s;
  // sclk and frame sync idle high: synchronise from that level after reset
  pin_sync #(.WIDTH(5), .INIT(5'h18)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({sclk,
                frame_sync_n,
                sdin,
                general_pin_zero_in,
                general_pin_one_in}),
    .sync_out (pins_s)
  );
  assign sclk_s = pins_s[4];
  assign fs_n_s = pins_s[3];
  assign sdin_s = pins_s[2];
  assign gp0_s  = pins_s[1];
  assign gp1_s  = pins_s[0];

  reg                    sclk_d;
  reg                    fs_d;
  reg [`FRAME_BITS-1:0]  shift_in;
  reg [`FRAME_CNT_W-1:0] bit_cnt;
  reg [`FRAME_BITS-1:0]  shift_out;
  reg [`FRAME_BITS-1:0]  readback;
  reg [5:0]              ctrl;
  reg [15:0]             input_data [0:3];
  reg [`RANGE_W-1:0]     range_r    [0:3];
  reg [`FINE_W-1:0]      fine_r     [0:3];
  reg [`OFFSET_W-1:0]    offset_r   [0:3];
  reg [15:0]             dac_r      [0:3];
  reg                    frame_ok_d;
  wire sclk_fall = sclk_d & ~sclk_s;
  wire sclk_rise = ~sclk_d & sclk_s;
  wire fs_start  = fs_d & ~fs_n_s;
  wire fs_end    = ~fs_d & fs_n_s;
  // a short frame is dropped: acting on partial bits would corrupt state
  wire frame_ok  = fs_end & (bit_cnt == `FRAME_BITS);

  wire                    is_read = shift_in[`BIT_DIR];
  wire [2:0]              sel     = shift_in[`SEL_HI:`SEL_LO];
  wire [2:0]              adr     = shift_in[`ADR_HI:`ADR_LO];
  wire [15:0]             payload = shift_in[15:0];

  // a control write is the only frame that moves the control word
  wire                    ctrl_write = frame_ok & ~is_read & (sel == `SEL_FUNCTION) & (adr == `FN_CONTROL);
  // both codings clear to 0x0000; kept apart so either code can change
  wire [15:0]             clear_code = twos_complement ? `CODE_MID : `CODE_NEG_FULL;

  function hit;
    input [2:0] a;
    input [1:0] ch;
    begin
      hit = (a == `ADR_ALL) | (a == {1'b0, ch});
    end
  endfunction

  function [15:0] rb_word;
    input [2:0] s;
    input [1:0] ch;
    reg   [5:0] cw;
    begin
      cw = ctrl;
      // input pins report live level instead of stored value
      if (!ctrl[`CW_P1_DIR]) cw[`CW_P1_VAL] = gp1_s;
      if (!ctrl[`CW_P0_DIR]) cw[`CW_P0_VAL] = gp0_s;
      case (s)
        `SEL_FUNCTION: rb_word = {10'h000, cw};
        `SEL_DATA:     rb_word = input_data[ch];
        `SEL_COARSE:   rb_word = {14'h0000, range_r[ch]};
        `SEL_FINE:     rb_word = {10'h000, fine_r[ch]};
        `SEL_OFFSET:   rb_word = {8'h00, offset_r[ch]};
        default:       rb_word = 16'h0000;
      endcase
    end
  endfunction

  integer i;
  always @(posedge clk) begin
    if (srst) begin
      shift_in  <= 24'h000000;
      bit_cnt   <= 5'h00;
      shift_out <= 24'h000000;
      readback  <= 24'h000000;
      for (i = 0; i < 4; i = i + 1) begin
        input_data[i] <= 16'h0000;
        range_r[i]    <= 2'h0;
        fine_r[i]     <= 6'h00;
        offset_r[i]   <= 8'h00;
        dac_r[i]      <= 16'h0000;
      end
    end else begin
      if (fs_start) begin
        bit_cnt   <= 5'h00;
        // pending readback goes out in the frame after the request
        shift_out <= readback;
        readback  <= 24'h000000;
      end else if (!fs_n_s) begin
        if (sclk_fall && bit_cnt != `FRAME_BITS) begin
          shift_in <= {shift_in[`FRAME_BITS-2:0], sdin_s};
          bit_cnt  <= bit_cnt + 5'h01;
        end
        if (sclk_rise && bit_cnt != 5'h00)
          shift_out <= {shift_out[`FRAME_BITS-2:0], 1'b0};
      end
      if (frame_ok) begin
        if (is_read) begin
          // channel code 100 on readback returns the first channel
          readback <= {1'b1, 1'b0, sel, adr, rb_word(sel, adr[1:0])};
        end else begin
          case (sel)
            `SEL_FUNCTION: begin
              case (adr)
                `FN_NOP: begin
                end
                `FN_CONTROL: begin
                end
                `FN_CLEAR: begin
                  for (i = 0; i < 4; i = i + 1)
                    dac_r[i] <= clear_code;
                end
                `FN_LOAD: begin
                  for (i = 0; i < 4; i = i + 1)
                    dac_r[i] <= input_data[i];
                end
                default: begin
                end
              endcase
            end
            `SEL_DATA: begin
              for (i = 0; i < 4; i = i + 1)
                if (hit(adr, i[1:0])) input_data[i] <= payload;
            end
            `SEL_COARSE: begin
              for (i = 0; i < 4; i = i + 1)
                if (hit(adr, i[1:0])) range_r[i] <= payload[1:0];
            end
            `SEL_FINE: begin
              for (i = 0; i < 4; i = i + 1)
                if (hit(adr, i[1:0])) fine_r[i] <= payload[`FINE_W-1:0];
            end
            `SEL_OFFSET: begin
              for (i = 0; i < 4; i = i + 1)
                if (hit(adr, i[1:0])) offset_r[i] <= payload[`OFFSET_W-1:0];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // edge detectors start at the idle-high level of both pins
  always @(posedge clk) begin
    if (srst) begin
      sclk_d <= 1'b1;
      fs_d   <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      fs_d   <= fs_n_s;
    end
  end

  // control word: moved only by a complete control write
  always @(posedge clk) begin
    if (srst) begin
      ctrl <= `CW_RESET;
    end else if (ctrl_write) begin
      ctrl[`CW_GND_ADJ] <= payload[`CW_GND_ADJ];
      ctrl[`CW_P1_DIR]  <= payload[`CW_P1_DIR];
      ctrl[`CW_P0_DIR]  <= payload[`CW_P0_DIR];
      ctrl[`CW_SDO_DIS] <= payload[`CW_SDO_DIS];
      // value kept only while pin is output after this write
      if (payload[`CW_P1_DIR]) ctrl[`CW_P1_VAL] <= payload[`CW_P1_VAL];
      if (payload[`CW_P0_DIR]) ctrl[`CW_P0_VAL] <= payload[`CW_P0_VAL];
    end
  end

  // registered outputs, one block each
  // done lags frame_ok by two so it marks the cycle the outputs move
  always @(posedge clk) begin
    if (srst) begin
      frame_ok_d <= 1'b0;
    end else begin
      frame_ok_d <= frame_ok;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      frame_done <= 1'b0;
    end else begin
      frame_done <= frame_ok_d;
    end
  end

  // pins stay inputs until a control write says otherwise
  always @(posedge clk) begin
    if (srst) begin
      general_pin_zero_oe <= 1'b0;
    end else begin
      general_pin_zero_oe <= ctrl[`CW_P0_DIR];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      general_pin_zero_out <= 1'b0;
    end else begin
      general_pin_zero_out <= ctrl[`CW_P0_VAL];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      general_pin_one_oe <= 1'b0;
    end else begin
      general_pin_one_oe <= ctrl[`CW_P1_DIR];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      general_pin_one_out <= 1'b0;
    end else begin
      general_pin_one_out <= ctrl[`CW_P1_VAL];
    end
  end

  // compensation enable follows its control bit
  always @(posedge clk) begin
    if (srst) begin
      ground_adjust_en <= 1'b0;
    end else begin
      ground_adjust_en <= ctrl[`CW_GND_ADJ];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      serial_out_pin <= 1'b0;
    end else begin
      serial_out_pin <= shift_out[`FRAME_BITS-1];
    end
  end

  // driver off when disabled or outside a frame
  always @(posedge clk) begin
    if (srst) begin
      serial_out_pin_oe <= 1'b0;
    end else begin
      serial_out_pin_oe <= ~ctrl[`CW_SDO_DIS] & ~fs_n_s;
    end
  end

  // per-channel values packed channel three first
  always @(posedge clk) begin
    if (srst) begin
      dac_output_code <= 64'h0;
    end else begin
      dac_output_code <= {dac_r[3], dac_r[2],
                          dac_r[1], dac_r[0]};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      range_codes <= 8'h00;
    end else begin
      range_codes <= {range_r[3], range_r[2],
                      range_r[1], range_r[0]};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      fine_gains <= 24'h000000;
    end else begin
      fine_gains <= {fine_r[3], fine_r[2],
                     fine_r[1], fine_r[0]};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      offsets <= 32'h00000000;
    end else begin
      offsets <= {offset_r[3], offset_r[2],
                  offset_r[1], offset_r[0]};
    end
  end
endmodule // quad_dac_serial_command_decode
`default_nettype wire

// [tb/host_serial_model.sv]
// Purpose: host serial port model
// Assumes: sclk idles high, bits go msb first
// Notes: sdin shows inverse of last bit between frames
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  output logic      sclk,
  output logic      frame_sync_n,
  output logic      sdin,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_pin_oe
);
  logic [23:0] rx;
  logic        oe_seen;
  initial begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    sdin = 1'b0;
  end
  // short frames come from n below 24
  task automatic send(input logic [23:0] f, input int n);
    int i;
    oe_seen = 1'b0;
    frame_sync_n = 1'b0;
    for (i = 23; i > 23 - n; i--) begin
      sdin = f[i];
      #62.5 rx = {rx[22:0], serial_out_pin};
      oe_seen |= serial_out_pin_oe;
      sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
    #62.5 frame_sync_n = 1'b1;
    sdin = ~sdin;
    #250;
  endtask
endmodule // host_serial_model
`default_nettype wire

// [tb/dac_decode_properties.sv]
// Purpose: port assertions for the command decoder
// Assumes: frame_done marks every change of the code, gain and control outputs
// Notes: bound from the testbench top
`timescale 1ns/1ps
`default_nettype none
module dac_decode_checker (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        frame_sync_n,
  input wire logic        general_pin_zero_out,
  input wire logic        general_pin_zero_oe,
  input wire logic        general_pin_one_out,
  input wire logic        general_pin_one_oe,
  input wire logic        serial_out_pin_oe,
  input wire logic        ground_adjust_en,
  input wire logic [63:0] dac_output_code,
  input wire logic [7:0]  range_codes,
  input wire logic [23:0] fine_gains,
  input wire logic [31:0] offsets,
  input wire logic        frame_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_done_single: assert property (frame_done |=> !frame_done)
    else $error("done pulse too long");
  a_done_fs_high: assert property (frame_done |-> frame_sync_n && $past(frame_sync_n, 2))
    else $error("done inside a frame");
  a_reset_zero: assert property ($past(srst) |-> dac_output_code == 64'h0 && !ground_adjust_en
    && !serial_out_pin_oe && !general_pin_zero_oe && !general_pin_one_oe) else $error("not reset");
  a_dac_hold: assert property (!frame_done |-> $stable(dac_output_code))
    else $error("dac code moved");
  a_gain_hold: assert property (!frame_done |-> $stable({range_codes, fine_gains, offsets}))
    else $error("gain moved");
  a_ctrl_hold: assert property (!frame_done |-> $stable({ground_adjust_en, general_pin_zero_oe, general_pin_one_oe}))
    else $error("control moved");
  a_value_ignored: assert property (($changed(general_pin_zero_out) |-> general_pin_zero_oe)
    and ($changed(general_pin_one_out) |-> general_pin_one_oe)) else $error("input value stored");
  a_sdo_idle: assert property (frame_sync_n [*6] |=> !serial_out_pin_oe)
    else $error("sdo driven idle");
  c_done: cover property (frame_done);
  c_sdo: cover property ($rose(serial_out_pin_oe));
  c_pin: cover property (general_pin_one_oe && general_pin_one_out);
endmodule // dac_decode_checker
`default_nettype wire

// [tb/test_quad_dac_serial_command_decode.sv]
// Purpose: self-checking bench of the command decoder
// Assumes: host model paces frames at 125 ns sclk
// Notes: expected state kept in bench shadows
`timescale 1ns/1ps
`default_nettype none
module test_quad_dac_serial_command_decode;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        twos_complement = 1'b0;
  logic        p0_ext = 1'b0;
  logic        p1_ext = 1'b0;
  logic        sclk, frame_sync_n, sdin, general_pin_zero_in, general_pin_one_in, frame_done;
  logic        general_pin_zero_out, general_pin_zero_oe, general_pin_one_out, general_pin_one_oe;
  logic        serial_out_pin, serial_out_pin_oe, ground_adjust_en;
  logic [63:0] dac_output_code;
  logic [7:0]  range_codes;
  logic [23:0] fine_gains;
  logic [31:0] offsets;
  logic [15:0] in_d [4];
  logic [63:0] e_dac = 64'h0;
  logic [63:0] e_gain = 64'h0;
  logic [5:0]  e_cw = 6'h0;
  logic [5:0]  bad [8] = '{6'o10, 6'o60, 6'o71, 6'o25, 6'o02, 6'o03, 6'o06, 6'o07};
  int          fail_count = 0;
  int          checks_done = 0;
  int          k;
  always #5 clk = ~clk;
  // the pin wire follows whoever drives it
  assign general_pin_zero_in = general_pin_zero_oe ? general_pin_zero_out : p0_ext;
  assign general_pin_one_in = general_pin_one_oe ? general_pin_one_out : p1_ext;
  quad_dac_serial_command_decode dut (.clk, .srst, .sclk, .frame_sync_n, .sdin, .twos_complement,
    .general_pin_zero_in, .general_pin_one_in, .general_pin_zero_out, .general_pin_zero_oe,
    .general_pin_one_out, .general_pin_one_oe, .serial_out_pin, .serial_out_pin_oe,
    .ground_adjust_en, .dac_output_code, .range_codes, .fine_gains, .offsets, .frame_done);
  host_serial_model host (.sclk, .frame_sync_n, .sdin, .serial_out_pin, .serial_out_pin_oe);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_state;
    chk(dac_output_code, e_dac);
    chk({range_codes, fine_gains, offsets}, e_gain);
    chk({ground_adjust_en, general_pin_one_oe, general_pin_one_out, general_pin_zero_oe,
         general_pin_zero_out}, {59'h0, e_cw[5:1]});
  endtask
  function automatic logic [15:0] cw_rb();
    return {10'h0, e_cw[5:4], e_cw[4] ? e_cw[3] : p1_ext, e_cw[2], e_cw[2] ? e_cw[1] : p0_ext, e_cw[0]};
  endfunction
  task automatic wr(input logic [2:0] s, input logic [2:0] a, input logic [15:0] d);
    int c;
    host.send({2'b00, s, a, d}, 24);
    for (c = 0; c < 4; c++)
      if (a == 3'h4 || a == 3'(c)) case (s)
        3'h2: in_d[c] = d;
        3'h3: e_gain[56 + 2 * c +: 2] = d[1:0];
        3'h4: e_gain[32 + 6 * c +: 6] = d[5:0];
        3'h5: e_gain[8 * c +: 8] = d[7:0];
        default: ;
      endcase
    if (s == 3'h0 && a == 3'h5) e_dac = {in_d[3], in_d[2], in_d[1], in_d[0]};
    if (s == 3'h0 && a == 3'h4) e_dac = 64'h0;
    if (s == 3'h0 && a == 3'h1) e_cw = {d[5:4], d[4] ? d[3] : e_cw[3], d[2], d[2] ? d[1] : e_cw[1], d[0]};
    check_state();
  endtask
  task automatic rd(input logic [2:0] s, input logic [2:0] a, input logic [15:0] d);
    host.send({2'b10, s, a, 16'h0}, 24);
    host.send(24'h0, 24);
    chk(host.rx, {2'b10, s, a, d});
    check_state();
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(46));
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    repeat (5) @(posedge clk);
    check_state();
    $display("reset test done");
    for (k = 0; k < 12; k++) wr(3'h2, k == 0 ? 3'h4 : 3'($urandom_range(3)), 16'($urandom));
    wr(3'h0, 3'h5, 16'($urandom));
    for (k = 0; k < 15; k++) wr(3'(3 + k / 5), 3'(k % 5), 16'($urandom));
    for (k = 0; k < 8; k++) wr(bad[k][5:3], bad[k][2:0], 16'($urandom));
    host.send({8'h10, 16'hbeef}, 23);
    check_state();
    $display("register test done");
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      #1 twos_complement = k[0];
      wr(3'h2, 3'h4, 16'($urandom) | 16'h1);
      wr(3'h0, 3'h5, 16'h0);
      wr(3'h0, 3'h4, 16'($urandom));
    end
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      #1 {p1_ext, p0_ext} = 2'($urandom);
      wr(3'h0, 3'h1, k == 0 ? 16'hffb2 : 16'($urandom) & 16'hfffe);
      rd(3'h0, 3'h1, cw_rb());
    end
    for (k = 0; k < 5; k++) rd(3'h2, 3'(k), in_d[k % 4]);
    wr(3'h0, 3'h1, 16'h0001);
    host.send(24'h0, 24);
    chk(host.oe_seen, 64'h0);
    wr(3'h0, 3'h1, 16'h0000);
    host.send(24'h0, 24);
    chk(host.oe_seen, 64'h1);
    $display("control test done");
    test_done();
  end
  initial begin
    #800us;
    fail_count++;
    test_done();
  end
endmodule // test_quad_dac_serial_command_decode
bind quad_dac_serial_command_decode dac_decode_checker chk_i (.clk, .srst, .frame_sync_n,
  .general_pin_zero_out, .general_pin_zero_oe, .general_pin_one_out, .general_pin_one_oe,
  .serial_out_pin_oe, .ground_adjust_en, .dac_output_code, .range_codes, .fine_gains, .offsets, .frame_done);
`default_nettype wire
